// file: keypad_wakeup_pkg.sv
// Constants, field positions and the state carrier of the keypad wakeup unit.
// Assumes an APB master with 32-bit data and a single 100 MHz clock domain.
// How it works
// (RULE1) Eight pin enable bits; a disabled input never sets the flag.
// (RULE2) Per-pin polarity: 0 means falling edge or low level, 1 rising or high.
// (RULE3) Mode bit 0 of status/control: 0 edges only, 1 edges and levels.
// (RULE4) Falling edge: enabled input sampled 1 then 0 on successive clocks.
// (RULE5) Rising edge: enabled input sampled 0 then 1 on successive clocks.
// (RULE6) An edge counts only after the input was at its deasserted level.
// (RULE7) Any valid edge, or asserted level in level mode, sets flag bit 3.
// (RULE8) Request output is flag AND request enable bit 1.
// (RULE9) Writing 1 to acknowledge bit 2 clears the flag; bit reads 0.
// (RULE10) Writes to the flag position never change the flag.
// (RULE11) In level mode acknowledge clears only if no enabled input asserted.
// (RULE12) Edge mode: no latch while another enabled input is already asserted.
// (RULE13) Status/control bits 7 to 4 always read 0.
// (RULE14) Pull select exported per pin: pullup for polarity 0, pulldown for 1.
// (RULE15) In wait mode an enabled input with request enable wakes the CPU.
// (RULE16) In shallow stop an enabled input with request enable wakes the CPU.
// (RULE17) Deep stop disables the unit and returns it to the reset state.
// (RULE18) Debug halt does not stop detection, flagging or requests.
// (RULE19) Software initialises: mask, polarity, pulls, enables, acknowledge, unmask.
// (RULE20) Software keeps keypad function off on pins used for display duty.
// (RULE21) Reset clears all control bits and the flag.

package keypad_wakeup_pkg;

  localparam int          NUM_PINS     = 8;
  localparam int          ADDR_W       = 12;

  // Register byte offsets on the APB.
  localparam logic [11:0] OFF_STATUS   = 12'h000;
  localparam logic [11:0] OFF_PIN_EN   = 12'h004;
  localparam logic [11:0] OFF_POLARITY = 12'h008;

  // Field positions inside the status/control register.
  localparam int          BIT_MODE     = 0;
  localparam int          BIT_REQ_EN   = 1;
  localparam int          BIT_ACK      = 2;
  localparam int          BIT_FLAG     = 3;

  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;

  // Whole state of the unit, registered in one place.
  typedef struct packed {
    logic [7:0]  pin_en;
    logic [7:0]  polarity;
    logic        mode;
    logic        req_en;
    logic        flag;
    logic [7:0]  prev;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic        wake;
  } state_s;

endpackage : keypad_wakeup_pkg

// file: keypad_wakeup_unit.sv
// Keypad wakeup unit: eight key inputs, one shared flag, one maskable request.
// Assumes key inputs already synchronous to i_clk and an APB master on the bus.
`timescale 1ns/1ps

module keypad_wakeup_unit
  import keypad_wakeup_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [7:0]        i_key_input_pins,
  input  wire logic              i_low_power,
  input  wire logic              i_deep_stop,
  output logic                   o_pready,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  output logic                   o_irq,
  output logic                   o_wakeup,
  output logic [7:0]             o_pull_select
);

  // Every register of the unit lives in state_r, including the APB answer and
  // the two request outputs, so each output is a flip-flop by construction.
  // The cost is a wide struct that is copied whole each cycle.
  state_s state_r;
  state_s state_nxt;

  // Limitations a user must know.
  // Shallow stop detection is clocked here; the unit needs i_clk running while
  // i_low_power is high, or no wakeup can be seen.
  // Deep stop is taken as a synchronous clear, so i_deep_stop must be held high
  // for at least one clock edge before the clock is stopped.
  // A key that bounces is not filtered; every clean edge can set the flag again.

  logic [7:0] cur_asserted;
  logic [7:0] prev_asserted;
  logic [7:0] edge_hit;
  logic       setup_phase;
  logic       write_access;
  logic       ack_write;
  logic       set_cond;
  logic       clear_ok;

  // Per-pin asserted decode; the same decode serves the current and previous sample.
  function automatic logic [7:0] asserted_of(input logic [7:0] pins,
                                             input logic [7:0] pol,
                                             input logic [7:0] en);
    asserted_of = en & ~(pins ^ pol);
  endfunction : asserted_of

  // Address decode for the error answer; the read mux decodes the address itself.
  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = (addr == OFF_STATUS) || (addr == OFF_PIN_EN) || (addr == OFF_POLARITY);
  endfunction : mapped

  // Read image of a register; unused and acknowledge bits read as zero.
  function automatic logic [31:0] read_of(input logic [ADDR_W-1:0] addr, input state_s s);
    logic [31:0] v;
    v = RST_WORD;
    unique case (addr)
      OFF_STATUS:
      begin
        v[BIT_MODE]   = s.mode;
        v[BIT_REQ_EN] = s.req_en;
        v[BIT_FLAG]   = s.flag; // RULE13
      end
      OFF_PIN_EN:   v[7:0] = s.pin_en;
      OFF_POLARITY: v[7:0] = s.polarity;
      default:      v = RST_WORD;
    endcase
    read_of = v;
  endfunction : read_of

  // Edge detection per pin: previous sample deasserted, present sample asserted.
  // The polarity in force now is applied to both samples, so a polarity change
  // while a pin sits at its new asserted level yields no edge.
  // Only a deasserted-to-asserted step counts, which keeps a held key from
  // producing a fresh event on every clock.
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : g_edge
      assign edge_hit[g] = cur_asserted[g] & ~prev_asserted[g]; // RULE4 RULE5 RULE6
    end
  endgenerate

  // Detection and bus decode terms.
  assign cur_asserted  = asserted_of(i_key_input_pins, state_r.polarity, state_r.pin_en); // RULE1 RULE2
  assign prev_asserted = asserted_of(state_r.prev, state_r.polarity, state_r.pin_en);
  assign setup_phase   = i_psel & ~i_penable;
  assign write_access  = i_psel & i_penable & state_r.pready & i_pwrite;
  assign ack_write     = write_access && (i_paddr == OFF_STATUS) && i_pwdata[BIT_ACK]; // RULE9
  // Edge mode latches an edge only if no enabled pin was already asserted.
  // Level mode also sets on any asserted level.
  assign set_cond      = state_r.mode ? ((|edge_hit) || (|cur_asserted))     // RULE3 RULE7
                                      : ((|edge_hit) && !(|prev_asserted)); // RULE12
  assign clear_ok      = !state_r.mode || !(|cur_asserted);                 // RULE11

  // Next-state logic: registers, flag, request, wakeup and APB answer.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.prev = i_key_input_pins;

    // Register writes take effect on the access edge only.
    if (write_access)
    begin
      unique case (i_paddr)
        OFF_STATUS:
        begin
          state_nxt.mode   = i_pwdata[BIT_MODE];
          state_nxt.req_en = i_pwdata[BIT_REQ_EN]; // RULE10
        end
        OFF_PIN_EN:   state_nxt.pin_en   = i_pwdata[7:0];
        OFF_POLARITY: state_nxt.polarity = i_pwdata[7:0];
        default:      state_nxt.pin_en   = state_r.pin_en;
      endcase
    end

    // A set arriving with an acknowledge wins; a blocked acknowledge leaves it set.
    if (set_cond)
    begin
      state_nxt.flag = 1'b1; // RULE7
    end
    else if (ack_write && clear_ok)
    begin
      state_nxt.flag = 1'b0; // RULE9 RULE11
    end

    // Zero-wait APB: read data and error are prepared during setup.
    // Read data is thus one cycle old; a flag set during the access cycle
    // shows on the next read, which software polling tolerates.
    state_nxt.pready  = setup_phase;
    state_nxt.prdata  = setup_phase ? read_of(i_paddr, state_r) : RST_WORD;
    state_nxt.pslverr = setup_phase && !mapped(i_paddr);

    // Debug halt is not an input here, so detection keeps running through it.
    state_nxt.irq  = state_nxt.flag & state_nxt.req_en; // RULE8 RULE18
    state_nxt.wake = i_low_power & state_nxt.req_en
                     & (state_nxt.flag | (|cur_asserted)); // RULE15 RULE16

    // Deep stop holds every bit but the pin sample at its reset value, so wakeup finds it reset.
    if (i_deep_stop)
    begin
      state_nxt          = '0; // RULE17
      state_nxt.prev     = i_key_input_pins;
      state_nxt.pin_en   = RST_BYTE;
      state_nxt.polarity = RST_BYTE;
      state_nxt.prdata   = RST_WORD;
    end
  end

  // Single state register with asynchronous reset to constants.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= '0; // RULE21
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // All outputs come straight from the state register.
  assign o_pready      = state_r.pready;
  assign o_prdata      = state_r.prdata;
  assign o_pslverr     = state_r.pslverr;
  assign o_irq         = state_r.irq;
  assign o_wakeup      = state_r.wake;
  assign o_pull_select = state_r.polarity; // RULE14

  // Checks that tie the flag and request to their causes.
  // They assume an APB master that holds address and data through the access
  // phase, as the protocol demands; a master that changes them early would
  // trip the bus checks below even though the unit behaved correctly.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_edge_sets;
    !state_r.mode && set_cond && !i_deep_stop |=> state_r.flag;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("Edge did not set flag"); // RULE7

  property p_level_sets;
    state_r.mode && (|cur_asserted) && !i_deep_stop |=> state_r.flag && $past(state_r.mode);
  endproperty
  a_level_sets: assert property (p_level_sets) else $error("Level did not set flag"); // RULE7

  property p_ack_blocked;
    state_r.mode && ack_write && (|cur_asserted) && !i_deep_stop |=> state_r.flag;
  endproperty
  a_ack_blocked: assert property (p_ack_blocked) else $error("Ack cleared while asserted"); // RULE11

  property p_ack_clears;
    ack_write && !set_cond && clear_ok && !i_deep_stop |=> !state_r.flag && !o_irq;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("Ack failed to clear flag"); // RULE9

  property p_irq_mask;
    o_irq == (state_r.flag && state_r.req_en);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("Request not flag and enable"); // RULE8

  property p_disabled_quiet;
    state_r.pin_en == RST_BYTE && !state_r.flag |=> !state_r.flag;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("Disabled pins set flag"); // RULE1

  property p_edge_blocked;
    !state_r.mode && (|prev_asserted) && !state_r.flag |=> !state_r.flag;
  endproperty
  a_edge_blocked: assert property (p_edge_blocked) else $error("Edge latched while asserted"); // RULE12

  property p_read_zero;
    o_pready && !i_pwrite && i_paddr == OFF_STATUS
      |-> o_prdata[7:4] == 4'h0 && !o_prdata[BIT_ACK];
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("Reserved status bits read 1"); // RULE13

  property p_deep_reset;
    i_deep_stop |=> state_r.pin_en == RST_BYTE && !state_r.flag && !o_irq && !o_wakeup;
  endproperty
  a_deep_reset: assert property (p_deep_reset) else $error("Deep stop left state"); // RULE17

  property p_flag_write;
    write_access && i_paddr == OFF_STATUS && i_pwdata[BIT_FLAG] && !state_r.flag
      && !set_cond |=> !state_r.flag;
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("Write set the flag"); // RULE10

  // The answer comes exactly one cycle after the setup edge.
  property p_pready_answer;
    setup_phase && !i_deep_stop |=> o_pready;
  endproperty
  a_pready_answer: assert property (p_pready_answer) else $error("No ready after setup");

  // Ready is a one-cycle pulse, never a level.
  property p_pready_single;
    o_pready |=> !o_pready;
  endproperty
  a_pready_single: assert property (p_pready_single) else $error("Ready stood two cycles");

  // An unmapped address is answered with an error.
  property p_err_unmapped;
    setup_phase && !mapped(i_paddr) && !i_deep_stop |=> o_pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("Unmapped without error");

  // A mapped address never gets an error.
  property p_err_mapped;
    o_pready && mapped(i_paddr) |-> !o_pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("Mapped with error");

  // Read data is zero whenever no answer stands.
  property p_prdata_idle;
    !o_pready |-> o_prdata == RST_WORD;
  endproperty
  a_prdata_idle: assert property (p_prdata_idle) else $error("Read data outside answer");

  // Each register is one byte; the upper bits of the word read zero.
  property p_prdata_upper;
    o_prdata[31:8] == 24'h00_0000;
  endproperty
  a_prdata_upper: assert property (p_prdata_upper) else $error("Upper read bits set"); // RULE13

  // A pin enable write lands in full.
  property p_pin_en_write;
    write_access && i_paddr == OFF_PIN_EN && !i_deep_stop
      |=> state_r.pin_en == $past(i_pwdata[7:0]);
  endproperty
  a_pin_en_write: assert property (p_pin_en_write) else $error("Pin enable lost"); // RULE1

  // A polarity write reaches the pull select output.
  property p_polarity_write;
    write_access && i_paddr == OFF_POLARITY && !i_deep_stop
      |=> o_pull_select == $past(i_pwdata[7:0]);
  endproperty
  a_polarity_write: assert property (p_polarity_write) else $error("Polarity lost"); // RULE2 RULE14

  // A status write sets mode and request enable.
  property p_mode_write;
    write_access && i_paddr == OFF_STATUS && !i_deep_stop
      |=> state_r.mode == $past(i_pwdata[BIT_MODE])
          && state_r.req_en == $past(i_pwdata[BIT_REQ_EN]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("Status write lost"); // RULE3 RULE8

  // A write to an unmapped address changes no control bit.
  property p_err_no_write;
    write_access && !mapped(i_paddr) && !i_deep_stop
      |=> $stable(state_r.pin_en) && $stable(state_r.polarity)
          && $stable(state_r.mode) && $stable(state_r.req_en);
  endproperty
  a_err_no_write: assert property (p_err_no_write) else $error("Unmapped write landed");

  // A status read shows the flag as it stood at the setup edge.
  property p_read_status;
    o_pready && !i_pwrite && i_paddr == OFF_STATUS
      |-> o_prdata[BIT_FLAG] == $past(state_r.flag);
  endproperty
  a_read_status: assert property (p_read_status) else $error("Flag read wrong"); // RULE7

  // The flag rises only when some enabled pin was asserted.
  property p_rose_cause;
    $rose(state_r.flag) |-> $past(|cur_asserted);
  endproperty
  a_rose_cause: assert property (p_rose_cause) else $error("Flag rose without cause"); // RULE1 RULE7

  // Without an acknowledge the flag stays set.
  property p_flag_holds;
    state_r.flag && !ack_write && !i_deep_stop |=> state_r.flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("Flag dropped by itself"); // RULE9

  // Level mode clears on acknowledge once every enabled pin is deasserted.
  property p_level_clear;
    state_r.mode && ack_write && !(|cur_asserted) && !i_deep_stop |=> !state_r.flag;
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("Level ack did not clear"); // RULE11

  // Edge mode clears on acknowledge when no pin is asserted.
  property p_edge_clear;
    !state_r.mode && ack_write && !(|cur_asserted) && !i_deep_stop |=> !state_r.flag;
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("Edge ack did not clear"); // RULE9

  // Wakeup is masked by the request enable.
  property p_wake_mask;
    o_wakeup |-> state_r.req_en;
  endproperty
  a_wake_mask: assert property (p_wake_mask) else $error("Wakeup while masked"); // RULE15 RULE16

  // A pending flag in low power keeps the wakeup up.
  property p_wake_flag;
    i_low_power && state_r.req_en && state_r.flag && !write_access && !i_deep_stop
      |=> o_wakeup;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("Pending flag gave no wakeup"); // RULE16

  // No wakeup while the processor runs.
  property p_wake_awake;
    !i_low_power |=> !o_wakeup;
  endproperty
  a_wake_awake: assert property (p_wake_awake) else $error("Wakeup while running"); // RULE15

  // Clearing request enable masks the request at once.
  property p_mask_irq;
    write_access && i_paddr == OFF_STATUS && !i_pwdata[BIT_REQ_EN] |=> !o_irq;
  endproperty
  a_mask_irq: assert property (p_mask_irq) else $error("Request not masked"); // RULE8

  // A request only rises with the flag set.
  property p_irq_rise;
    $rose(o_irq) |-> state_r.flag;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("Request without flag"); // RULE8

  // With every pin disabled nothing counts as asserted.
  property p_disabled_none;
    state_r.pin_en == RST_BYTE |-> !(|cur_asserted);
  endproperty
  a_disabled_none: assert property (p_disabled_none) else $error("Disabled pin asserted"); // RULE1

  // Deep stop also clears polarity and any bus answer.
  property p_deep_hold;
    i_deep_stop |=> o_pull_select == RST_BYTE && !o_pready;
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("Deep stop kept polarity"); // RULE17

  // Main scenarios that the bench is expected to reach.
  c_edge_irq:   cover property (!state_r.mode && set_cond && state_r.req_en ##1 o_irq);
  c_ack_block:  cover property (state_r.mode && ack_write && (|cur_asserted));
  c_wake:       cover property (i_low_power ##1 o_wakeup);
  c_level_set:  cover property (state_r.mode && (|cur_asserted) ##1 state_r.flag);
  c_deep:       cover property (i_deep_stop ##1 !state_r.flag);

endmodule : keypad_wakeup_unit

// file: key_source.sv
// Model of a key matrix on the key inputs of the keypad wakeup unit.
// Assumes press requests come from the bench and that pulls follow o_pull_select.
`timescale 1ns/1ps

module key_source (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_press,
  input  wire logic [7:0] i_pull_select,
  output logic [7:0]      o_pins = 8'hFF
);
  // A released key leaves its pin at the pull level, since nothing else drives it.
  // A pressed key shorts the pin to the opposite rail. No pin here serves a display.
  always @(posedge i_clk)
  begin
    o_pins <= ~(i_press ^ i_pull_select);
  end
endmodule : key_source

// file: keypad_wakeup_unit_tb_top.sv
// Self-checking bench for the keypad wakeup unit with an APB master and a key model.
// Assumes the unit answers APB transfers with pready and has one 100 MHz clock.
`timescale 1ns/1ps

module keypad_wakeup_unit_tb_top
  import keypad_wakeup_pkg::*;
;
  logic              clk;
  logic              resetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic              low_power = 1'b0;
  logic              deep_stop = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [7:0]        press = '0;
  logic [31:0]       prdata, rd;
  logic              pready, pslverr, irq, wakeup, err;
  logic [7:0]        pins, pull_sel;
  int                n_fail = 0;
  int                n_compared = 0;

  keypad_wakeup_unit keypad_wakeup_unit_inst (
    .i_clk(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_key_input_pins(pins),
    .i_low_power(low_power), .i_deep_stop(deep_stop), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .o_irq(irq), .o_wakeup(wakeup),
    .o_pull_select(pull_sel));

  key_source key_source_inst (.i_clk(clk), .i_press(press), .i_pull_select(pull_sel),
                              .o_pins(pins));

  // Free-running clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen, which may take any time.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Lets the key model, sampling and the registered request all land before a look.
  task automatic keys(input logic [7:0] v);
    @(posedge clk);
    press <= v;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : keys

  task automatic init(input logic [7:0] en, input logic [7:0] pol, input logic mode);
    apb(1'b1, OFF_STATUS, 32'h0);
    apb(1'b1, OFF_POLARITY, {24'h0, pol});
    apb(1'b1, OFF_PIN_EN, {24'h0, en});
    apb(1'b1, OFF_STATUS, 32'h4);
    apb(1'b1, OFF_STATUS, {30'h0, 1'b1, mode});
  endtask : init

  task automatic t_regs();
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'(err), 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, RST_WORD);
    end
    apb(1'b1, OFF_POLARITY, 32'hFF);
    apb(1'b1, OFF_PIN_EN, 32'hFF);
    apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, OFF_POLARITY, 32'h0);
    chk(rd, 32'hFF);
    chk(32'(pull_sel), 32'hFF);
  endtask : t_regs

  // Every pin alone, polarity alternating, with the other pins pressed while disabled.
  task automatic t_edges();
    for (int p = 0; p < 8; p++)
    begin
      init(8'(1 << p), {8{p[0]}}, 1'b0);
      keys(~8'(1 << p));
      chk(32'(irq), 32'h0);
      keys(8'hFF);
      chk(32'(irq), 32'h1);
      keys(8'h00);
      chk(32'(irq), 32'h1);
      apb(1'b1, OFF_STATUS, 32'h6);
      keys(8'h00);
      chk(32'(irq), 32'h0);
    end
  endtask : t_edges

  task automatic t_block();
    init(8'h03, 8'h00, 1'b0);
    keys(8'h01);
    apb(1'b1, OFF_STATUS, 32'h6);
    keys(8'h03);
    chk(32'(irq), 32'h0);
    keys(8'h04);
    apb(1'b1, OFF_PIN_EN, 32'h04);
    keys(8'h04);
    chk(32'(irq), 32'h0);
  endtask : t_block

  task automatic t_level();
    init(8'h10, 8'hFF, 1'b1);
    keys(8'h10);
    apb(1'b1, OFF_STATUS, 32'h7);
    keys(8'h10);
    chk(32'(irq), 32'h1);
    apb(1'b1, OFF_STATUS, 32'h1);
    keys(8'h10);
    chk(32'(irq), 32'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h9);
    keys(8'h00);
    apb(1'b1, OFF_STATUS, 32'h5);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h1);
  endtask : t_level

  task automatic t_power();
    init(8'h80, 8'h00, 1'b0);
    low_power <= 1'b1;
    keys(8'h80);
    chk(32'(wakeup), 32'h1);
    @(posedge clk);
    deep_stop <= 1'b1;
    keys(8'h00);
    chk(32'({irq, wakeup}), 32'h0);
    @(posedge clk);
    deep_stop <= 1'b0;
    low_power <= 1'b0;
    apb(1'b0, OFF_PIN_EN, 32'h0);
    chk(rd, RST_WORD);
  endtask : t_power

  // Main sequence: reset for four cycles, then each scenario in turn.
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_edges();
    t_block();
    t_level();
    t_power();
    conclude();
  end

  // Watchdog, far beyond the few hundred cycles the scenarios need.
  initial
  begin
    #200us;
    n_fail++;
    conclude();
  end
endmodule : keypad_wakeup_unit_tb_top
